//--- inc/tmi_defs.svh
`ifndef TMI_DEFS_SVH
`define TMI_DEFS_SVH

`define TMI_WORD_W        16
`define TMI_BITS_PER_WORD 16
`define TMI_BIT_POS_W     4
`define TMI_BIT_LEN_W     8
`define TMI_MEM_WORDS     17'h10000
`define TMI_COPY_OFS_BASE 16'h0000
`define TMI_ACC_RESET     16'h0000
`define TMI_FLAG_RESET    1'b0
`define TMI_CNT_ZERO      16'h0000
`define TMI_CNT_LAST      16'h0001

`endif

//--- inc/tmi_pkg.sv
package tmi_pkg;

    typedef enum logic [3:0] {
        TMI_OP_NOP        = 4'h0,
        TMI_OP_LOAD       = 4'h1,
        TMI_OP_LOAD_ADDR  = 4'h2,
        TMI_OP_LOAD_LABEL = 4'h3,
        TMI_OP_COPY       = 4'h4,
        TMI_OP_BIT_SET    = 4'h5,
        TMI_OP_BIT_CLEAR  = 4'h6,
        TMI_OP_FILL_CONST = 4'h7,
        TMI_OP_FILL_WORD  = 4'h8
    } tmi_op_type;

    typedef enum logic [2:0] {
        TMI_ST_IDLE  = 3'b000,
        TMI_ST_FETCH = 3'b001,
        TMI_ST_READ  = 3'b011,
        TMI_ST_WRITE = 3'b010,
        TMI_ST_DONE  = 3'b110
    } tmi_state_type;

    typedef enum logic [1:0] {
        TMI_JOB_COPY_IN  = 2'h0,
        TMI_JOB_COPY_OUT = 2'h1,
        TMI_JOB_BIT      = 2'h2,
        TMI_JOB_FILL     = 2'h3
    } tmi_job_type;

    typedef struct packed {
        tmi_state_type state;
        tmi_job_type   job;
        logic [15:0]   acc;
        logic [15:0]   stack1;
        logic [15:0]   stack2;
        logic          acc_label;
        logic          range_error;
        logic [15:0]   src;
        logic [15:0]   dst;
        logic [15:0]   remain;
        logic [15:0]   value;
        logic [3:0]    bit_pos;
        logic          set_bit;
        logic          done;
    } tmi_regs_type;

endpackage : tmi_pkg

//--- rtl/tmi_bit_locate.sv
`timescale 1ns/100ps
`include "tmi_defs.svh"

module tmi_bit_locate
    import tmi_pkg::*;
(
    // bit reference and table
    input  wire logic [15:0] bit_ref,
    input  wire logic [15:0] table_start,
    input  wire logic [7:0]  table_len,
    // located bit
    output logic      [15:0] word_addr,
    output logic      [3:0]  bit_pos,
    output logic             out_of_range
);

    logic [15:0] table_bits;

    always_comb begin
        table_bits   = {4'h0, table_len, 4'h0};
        bit_pos      = bit_ref[`TMI_BIT_POS_W-1:0];
        word_addr    = 16'(table_start + {4'h0, bit_ref[15:4]});
        out_of_range = (bit_ref >= table_bits);
    end

endmodule : tmi_bit_locate

//--- rtl/tmi_span_check.sv
`timescale 1ns/100ps
`include "tmi_defs.svh"

module tmi_span_check
    import tmi_pkg::*;
#(
    parameter logic [16:0] MEM_WORDS = `TMI_MEM_WORDS
)
(
    // span under test
    input  wire logic [15:0] start,
    input  wire logic [15:0] count,
    // verdict
    output logic             out_of_range
);

    logic [16:0] span_end;

    always_comb begin
        span_end     = {1'b0, start} + {1'b0, count};
        out_of_range = (span_end > MEM_WORDS);
    end

endmodule : tmi_span_check

//--- rtl/tmi_table_unit.sv
`timescale 1ns/100ps
`include "tmi_defs.svh"

// Overview of operation
// - copy word count from second stack level
// - first stack level offsets both areas
// - label in accumulator selects copy direction
// - operand gives destination; whole block copied
// - load_label_source only feeds copies into word memory
// - copy offsets start at zero, unchecked
// - copy past label area end not guarded
// - each load pushes accumulator and first level
// - bit set/clear changes exactly one bit
// - bit table length from first level, 0..FF
// - bit and fill start from accumulator
// - bit reference counts bits, sixteen per word
// - reference past table raises flag, no write
// - flag lasts until scan end or reuse
// - fill writes one value into table
// - fill count from first level, 0..FFFF
// - fill outside memory raises range flag
module tmi_table_unit
    import tmi_pkg::*;
#(
    parameter logic [16:0] MEM_WORDS = `TMI_MEM_WORDS
)
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // instruction stream
    input  wire logic        instr_valid,
    input  wire tmi_op_type  instr_op,
    input  wire logic [15:0] instr_operand,
    output logic             instr_ready,
    output logic             instr_done,
    // scan boundary
    input  wire logic        scan_end,
    // word memory port
    output logic      [15:0] wm_addr,
    output logic             wm_read,
    output logic             wm_write,
    output logic      [15:0] wm_wdata,
    input  wire logic [15:0] wm_rdata,
    // program memory port
    output logic      [15:0] pm_addr,
    output logic             pm_read,
    output logic             pm_write,
    output logic      [15:0] pm_wdata,
    input  wire logic [15:0] pm_rdata,
    // status
    output logic             range_error_flag,
    output logic      [15:0] acc_value,
    output logic      [15:0] stack1_value,
    output logic      [15:0] stack2_value
);

    tmi_regs_type state_reg;
    tmi_regs_type state_next;

    logic        accept;
    logic [15:0] copy_src_sum;
    logic [15:0] copy_dst_sum;
    logic [15:0] bit_word_addr;
    logic [3:0]  bit_pos;
    logic        bit_bad;
    logic        fill_bad;
    logic [15:0] bit_mask;

    tmi_bit_locate u_bit_locate (
        .bit_ref      (instr_operand),
        .table_start  (state_reg.acc),
        .table_len    (state_reg.stack1[7:0]),
        .word_addr    (bit_word_addr),
        .bit_pos      (bit_pos),
        .out_of_range (bit_bad)
    );

    tmi_span_check #(
        .MEM_WORDS (MEM_WORDS)
    ) u_span_check (
        .start        (state_reg.acc),
        .count        (state_reg.stack1),
        .out_of_range (fill_bad)
    );

    assign accept       = instr_valid && (state_reg.state == TMI_ST_IDLE);
    assign instr_ready  = (state_reg.state == TMI_ST_IDLE);
    assign instr_done   = state_reg.done;
    assign copy_src_sum = 16'(state_reg.acc + state_reg.stack1);
    assign copy_dst_sum = 16'(instr_operand + state_reg.stack1);
    assign bit_mask     = 16'h0001 << state_reg.bit_pos;

    assign range_error_flag = state_reg.range_error;
    assign acc_value        = state_reg.acc;
    assign stack1_value     = state_reg.stack1;
    assign stack2_value     = state_reg.stack2;

    always_comb begin
        state_next      = state_reg;
        state_next.done = 1'b0;
        if (scan_end) begin
            state_next.range_error = 1'b0;
        end
        unique case (state_reg.state)
            TMI_ST_IDLE: begin
                if (instr_valid) begin
                    unique case (instr_op)
                        TMI_OP_LOAD, TMI_OP_LOAD_ADDR, TMI_OP_LOAD_LABEL: begin
                            state_next.stack2    = state_reg.stack1;
                            state_next.stack1    = state_reg.acc;
                            state_next.acc       = instr_operand;
                            state_next.acc_label = (instr_op == TMI_OP_LOAD_LABEL);
                            state_next.done      = 1'b1;
                        end
                        TMI_OP_COPY: begin
                            // offsets are never range checked
                            state_next.job    = state_reg.acc_label ? TMI_JOB_COPY_IN
                                                                    : TMI_JOB_COPY_OUT;
                            state_next.remain = state_reg.stack2;
                            state_next.src    = copy_src_sum;
                            state_next.dst    = copy_dst_sum;
                            state_next.state  = (state_reg.stack2 == `TMI_CNT_ZERO) ? TMI_ST_DONE
                                                                                   : TMI_ST_READ;
                        end
                        TMI_OP_BIT_SET, TMI_OP_BIT_CLEAR: begin
                            state_next.job         = TMI_JOB_BIT;
                            state_next.range_error = bit_bad;
                            state_next.src         = bit_word_addr;
                            state_next.bit_pos     = bit_pos;
                            state_next.set_bit     = (instr_op == TMI_OP_BIT_SET);
                            state_next.state       = bit_bad ? TMI_ST_DONE : TMI_ST_READ;
                        end
                        TMI_OP_FILL_CONST, TMI_OP_FILL_WORD: begin
                            state_next.job         = TMI_JOB_FILL;
                            state_next.range_error = fill_bad;
                            state_next.dst         = state_reg.acc;
                            state_next.remain      = state_reg.stack1;
                            state_next.value       = instr_operand;
                            state_next.src         = instr_operand;
                            if (fill_bad || state_reg.stack1 == `TMI_CNT_ZERO) begin
                                state_next.state = TMI_ST_DONE;
                            end else if (instr_op == TMI_OP_FILL_WORD) begin
                                state_next.state = TMI_ST_FETCH;
                            end else begin
                                state_next.state = TMI_ST_WRITE;
                            end
                        end
                        default: begin
                            state_next.done = 1'b1;
                        end
                    endcase
                end
            end
            TMI_ST_FETCH: begin
                state_next.state = TMI_ST_READ;
            end
            TMI_ST_READ: begin
                if (state_reg.job == TMI_JOB_FILL) begin
                    state_next.value = wm_rdata;
                end
                state_next.state = TMI_ST_WRITE;
            end
            TMI_ST_WRITE: begin
                if (state_reg.job == TMI_JOB_BIT) begin
                    state_next.state = TMI_ST_DONE;
                end else begin
                    state_next.src    = 16'(state_reg.src + 16'h0001);
                    state_next.dst    = 16'(state_reg.dst + 16'h0001);
                    state_next.remain = 16'(state_reg.remain - 16'h0001);
                    if (state_reg.remain == `TMI_CNT_LAST) begin
                        state_next.state = TMI_ST_DONE;
                    end else if (state_reg.job == TMI_JOB_FILL) begin
                        state_next.state = TMI_ST_WRITE;
                    end else begin
                        state_next.state = TMI_ST_READ;
                    end
                end
            end
            TMI_ST_DONE: begin
                state_next.done  = 1'b1;
                state_next.state = TMI_ST_IDLE;
            end
            default: begin
                state_next.state = TMI_ST_IDLE;
            end
        endcase
    end

    always_comb begin
        wm_addr  = 16'h0000;
        wm_read  = 1'b0;
        wm_write = 1'b0;
        wm_wdata = 16'h0000;
        pm_addr  = 16'h0000;
        pm_read  = 1'b0;
        pm_write = 1'b0;
        pm_wdata = 16'h0000;
        unique case (state_reg.state)
            TMI_ST_FETCH: begin
                wm_read = 1'b1;
                wm_addr = state_reg.src;
            end
            TMI_ST_READ: begin
                if (state_reg.job == TMI_JOB_COPY_IN) begin
                    pm_read = 1'b1;
                    pm_addr = state_reg.src;
                end else if (state_reg.job != TMI_JOB_FILL) begin
                    wm_read = 1'b1;
                    wm_addr = state_reg.src;
                end
            end
            TMI_ST_WRITE: begin
                unique case (state_reg.job)
                    TMI_JOB_COPY_IN: begin
                        wm_write = 1'b1;
                        wm_addr  = state_reg.dst;
                        wm_wdata = pm_rdata;
                    end
                    TMI_JOB_COPY_OUT: begin
                        pm_write = 1'b1;
                        pm_addr  = state_reg.dst;
                        pm_wdata = wm_rdata;
                    end
                    TMI_JOB_BIT: begin
                        wm_write = 1'b1;
                        wm_addr  = state_reg.src;
                        wm_wdata = state_reg.set_bit ? (wm_rdata | bit_mask)
                                                     : (wm_rdata & ~bit_mask);
                    end
                    TMI_JOB_FILL: begin
                        wm_write = 1'b1;
                        wm_addr  = state_reg.dst;
                        wm_wdata = state_reg.value;
                    end
                endcase
            end
            default: begin
                wm_read = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg             <= '0;
            state_reg.state       <= TMI_ST_IDLE;
            state_reg.acc         <= `TMI_ACC_RESET;
            state_reg.range_error <= `TMI_FLAG_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    logic is_load;
    logic is_flag_op;
    assign is_load    = accept && (instr_op inside {TMI_OP_LOAD, TMI_OP_LOAD_ADDR, TMI_OP_LOAD_LABEL});
    assign is_flag_op = accept && (instr_op inside {TMI_OP_BIT_SET, TMI_OP_BIT_CLEAR,
                                                    TMI_OP_FILL_CONST, TMI_OP_FILL_WORD});

    AST_PUSH_LEVELS: assert property (is_load |=> state_reg.stack1 == $past(state_reg.acc)
        && state_reg.stack2 == $past(state_reg.stack1) && acc_value == $past(instr_operand))
        else $error("load did not push the stack");
    AST_COPY_LEN: assert property (accept && instr_op == TMI_OP_COPY && state_reg.stack2 != 16'h0000
        |=> state_reg.remain == $past(state_reg.stack2) && state_reg.state == TMI_ST_READ)
        else $error("copy length not taken from second level");
    AST_COPY_OFFSET: assert property (accept && instr_op == TMI_OP_COPY
        |=> state_reg.src == $past(copy_src_sum) && state_reg.dst == $past(copy_dst_sum))
        else $error("copy offset not applied to both areas");
    AST_COPY_DIR: assert property (state_reg.state == TMI_ST_READ && state_reg.job == TMI_JOB_COPY_IN
        |-> pm_read && !wm_read ##1 wm_write && !pm_write && wm_wdata == pm_rdata)
        else $error("label copy went the wrong way");
    AST_BIT_ONE: assert property (state_reg.state == TMI_ST_WRITE && state_reg.job == TMI_JOB_BIT
        |-> wm_wdata[state_reg.bit_pos] == state_reg.set_bit && ((wm_wdata ^ wm_rdata) & ~bit_mask) == 16'h0000)
        else $error("bit update touched other bits");
    AST_BIT_RANGE: assert property (accept && instr_op inside {TMI_OP_BIT_SET, TMI_OP_BIT_CLEAR}
        && bit_bad |=> range_error_flag && !wm_write ##1 instr_done && !wm_write)
        else $error("bad bit reference not flagged or memory written");
    AST_FLAG_SCAN: assert property (scan_end && !is_flag_op |=> !range_error_flag)
        else $error("flag survived scan end");
    AST_FILL_RANGE: assert property (accept && instr_op inside {TMI_OP_FILL_CONST, TMI_OP_FILL_WORD}
        |=> range_error_flag == $past(fill_bad))
        else $error("fill range flag wrong");
    AST_DONE_IDLE: assert property (instr_done |-> instr_ready && !wm_write && !pm_write
        && $past(state_reg.state) inside {TMI_ST_IDLE, TMI_ST_DONE})
        else $error("done raised while busy");

    // copy path
    AST_COPY_OUT_DIR: assert property (state_reg.state == TMI_ST_READ && state_reg.job == TMI_JOB_COPY_OUT
        |-> wm_read && !pm_read ##1 pm_write && !wm_write && pm_wdata == wm_rdata)
        else $error("word area copy went the wrong way");
    AST_LABEL_MARK: assert property (is_load |=> state_reg.acc_label == ($past(instr_op) == TMI_OP_LOAD_LABEL))
        else $error("label mark not tracking the last load");
    AST_COPY_EMPTY: assert property (accept && instr_op == TMI_OP_COPY && state_reg.stack2 == 16'h0000
        |=> !wm_write && !pm_write ##1 instr_done)
        else $error("empty copy moved data");
    AST_COPY_STEP: assert property (state_reg.state == TMI_ST_WRITE && state_reg.job != TMI_JOB_BIT
        |=> state_reg.remain == 16'($past(state_reg.remain) - 16'h0001)
        && state_reg.dst == 16'($past(state_reg.dst) + 16'h0001))
        else $error("block transfer did not advance");

    // bit path
    AST_BIT_LIMIT: assert property (accept && instr_op inside {TMI_OP_BIT_SET, TMI_OP_BIT_CLEAR}
        |=> range_error_flag == ($past(instr_operand) >= {4'h0, $past(state_reg.stack1[7:0]), 4'h0}))
        else $error("bit table length not taken from first level");
    AST_BIT_WORD: assert property (accept && instr_op inside {TMI_OP_BIT_SET, TMI_OP_BIT_CLEAR} && !bit_bad
        |=> wm_read && wm_addr == 16'($past(state_reg.acc) + ($past(instr_operand) >> 4)))
        else $error("bit word not counted from table start");

    // fill path
    AST_FILL_FIRST: assert property (accept && instr_op == TMI_OP_FILL_CONST && !fill_bad
        && state_reg.stack1 != 16'h0000 |=> wm_write && wm_addr == $past(state_reg.acc)
        && wm_wdata == $past(instr_operand))
        else $error("fill first word wrong");
    AST_FILL_SOURCE: assert property (accept && instr_op == TMI_OP_FILL_WORD && !fill_bad
        && state_reg.stack1 != 16'h0000 |=> wm_read && wm_addr == $past(instr_operand)
        ##2 wm_write && wm_wdata == $past(wm_rdata))
        else $error("fill source word not used");
    AST_FILL_BAD: assert property (accept && instr_op inside {TMI_OP_FILL_CONST, TMI_OP_FILL_WORD}
        && fill_bad |=> !wm_write && !wm_read ##1 instr_done && !wm_write)
        else $error("fill outside memory touched memory");

    // status and sequencing
    AST_FLAG_HOLD: assert property (!scan_end && !is_flag_op |=> $stable(range_error_flag))
        else $error("flag changed without a cause");
    AST_BUSY_HOLD: assert property (state_reg.state != TMI_ST_IDLE
        |=> $stable(acc_value) && $stable(stack1_value) && $stable(stack2_value))
        else $error("stack moved while busy");
    AST_ONE_AREA: assert property (!(wm_write && pm_write))
        else $error("both memories written at once");
    AST_WRITE_STATE: assert property ((wm_write || pm_write) |-> state_reg.state == TMI_ST_WRITE)
        else $error("memory written outside a write step");

    COV_COPY_IN:  cover property (state_reg.state == TMI_ST_WRITE && state_reg.job == TMI_JOB_COPY_IN);
    COV_COPY_OUT: cover property (state_reg.state == TMI_ST_WRITE && state_reg.job == TMI_JOB_COPY_OUT);
    COV_BIT_SET:  cover property (state_reg.state == TMI_ST_WRITE && state_reg.job == TMI_JOB_BIT);
    COV_FILL:     cover property (state_reg.state == TMI_ST_WRITE && state_reg.job == TMI_JOB_FILL);
    COV_FLAG:     cover property (is_flag_op ##1 range_error_flag);

endmodule : tmi_table_unit

//--- test/tmi_table_unit_test.sv
`timescale 1ns/100ps

module tmi_table_unit_test;
    import tmi_pkg::*;

    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        instr_valid = 1'b0;
    tmi_op_type  instr_op = TMI_OP_NOP;
    logic [15:0] instr_operand = 16'h0000;
    logic        instr_ready, instr_done, scan_end = 1'b0;
    logic [15:0] wm_addr, wm_wdata, pm_addr, pm_wdata;
    logic        wm_read, wm_write, pm_read, pm_write;
    logic [15:0] wm_rdata = 16'h0000;
    logic [15:0] pm_rdata = 16'h0000;
    logic        range_error_flag;
    logic [15:0] acc_value, stack1_value, stack2_value;
    logic [15:0] wmem [0:65535];
    logic [15:0] pmem [0:65535];
    int          wm_writes = 0;
    int          pm_writes = 0;
    int          last_lat;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    tmi_table_unit dut (
        .clock(clock), .reset(reset),
        .instr_valid(instr_valid), .instr_op(instr_op), .instr_operand(instr_operand),
        .instr_ready(instr_ready), .instr_done(instr_done), .scan_end(scan_end),
        .wm_addr(wm_addr), .wm_read(wm_read), .wm_write(wm_write), .wm_wdata(wm_wdata), .wm_rdata(wm_rdata),
        .pm_addr(pm_addr), .pm_read(pm_read), .pm_write(pm_write), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata),
        .range_error_flag(range_error_flag), .acc_value(acc_value),
        .stack1_value(stack1_value), .stack2_value(stack2_value)
    );

    always #25 clock = ~clock;

    // memories answer one cycle after a read; idle data lines keep toggling
    always @(posedge clock) begin
        wm_rdata <= wm_read ? wmem[wm_addr] : ~wm_rdata;
        pm_rdata <= pm_read ? pmem[pm_addr] : ~pm_rdata;
        if (wm_write === 1'b1) begin
            wmem[wm_addr] <= wm_wdata;
            wm_writes++;
        end
        if (pm_write === 1'b1) begin
            pmem[pm_addr] <= pm_wdata;
            pm_writes++;
        end
    end

    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check16

    task automatic check1(input logic got, input logic exp, input string msg);
        check16({15'h0000, got}, {15'h0000, exp}, msg);
    endtask : check1

    // present one instruction, wait for its completion, record latency
    task automatic exec(input tmi_op_type op, input logic [15:0] opd);
        int n;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_operand <= opd;
        @(negedge clock);
        check1(instr_ready, 1'b1, "ready before accept");
        @(posedge clock);
        instr_valid <= 1'b0;
        instr_op <= TMI_OP_NOP;
        n = 0;
        do begin
            @(negedge clock);
            n++;
            if (instr_done !== 1'b1) check1(instr_ready, 1'b0, "ready while busy");
        end while (instr_done !== 1'b1 && n < 600);
        check1(instr_done, 1'b1, "instruction finished");
        last_lat = n;
    endtask : exec

    task automatic load3(input tmi_op_type op, input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        exec(TMI_OP_LOAD, a);
        exec(TMI_OP_LOAD, b);
        exec(op, c);
    endtask : load3

    task automatic t_reset;
        @(negedge clock);
        check1(instr_ready, 1'b1, "ready in reset");
        check1(range_error_flag, 1'b0, "flag in reset");
        check16(stack2_value, 16'h0000, "stack2 in reset");
        repeat (8) @(posedge clock);
        reset <= 1'b0;
    endtask : t_reset

    task automatic t_copy_in;
        pmem[16'h0011] = 16'h1111;
        pmem[16'h0012] = 16'h2222;
        pmem[16'h0013] = 16'h3333;
        load3(TMI_OP_LOAD_LABEL, 16'h0003, 16'h0001, 16'h0010);
        check16(acc_value, 16'h0010, "acc after loads");
        check16(stack1_value, 16'h0001, "stack1 after loads");
        check16(stack2_value, 16'h0003, "stack2 after loads");
        exec(TMI_OP_COPY, 16'h0040);
        check16(16'(last_lat), 16'h0008, "copy in latency");
        check16(wmem[16'h0041], 16'h1111, "copy in word 0");
        check16(wmem[16'h0042], 16'h2222, "copy in word 1");
        check16(wmem[16'h0043], 16'h3333, "copy in word 2");
        check16(wmem[16'h0040], 16'h0000, "below copy block");
        check16(wmem[16'h0044], 16'h0000, "above copy block");
        check16(16'(pm_writes), 16'h0000, "no program writes");
    endtask : t_copy_in

    task automatic t_copy_out;
        wmem[16'h0052] = 16'ha5a5;
        wmem[16'h0053] = 16'h5a5a;
        load3(TMI_OP_LOAD_ADDR, 16'h0002, 16'h0002, 16'h0050);
        exec(TMI_OP_COPY, 16'h0020);
        check16(pmem[16'h0022], 16'ha5a5, "copy out word 0");
        check16(pmem[16'h0023], 16'h5a5a, "copy out word 1");
        check16(pmem[16'h0021], 16'h0000, "copy out below");
        check16(16'(wm_writes), 16'h0003, "no word writes");
        load3(TMI_OP_LOAD_ADDR, 16'h0000, 16'h0000, 16'h0050);
        exec(TMI_OP_COPY, 16'h0020);
        check16(16'(last_lat), 16'h0002, "empty copy latency");
        check16(16'(pm_writes), 16'h0002, "empty copy writes");
    endtask : t_copy_out

    task automatic t_bits;
        int w;
        wmem[16'h0060] = 16'hffff;
        exec(TMI_OP_LOAD, 16'h0002);
        exec(TMI_OP_LOAD_ADDR, 16'h0060);
        exec(TMI_OP_BIT_SET, 16'h001c);
        check16(16'(last_lat), 16'h0004, "bit latency");
        check16(wmem[16'h0061], 16'h1000, "bit set word 1");
        exec(TMI_OP_BIT_CLEAR, 16'h0000);
        check16(wmem[16'h0060], 16'hfffe, "bit clear word 0");
        exec(TMI_OP_BIT_SET, 16'h001f);
        check16(wmem[16'h0061], 16'h9000, "last bit of table");
        check1(range_error_flag, 1'b0, "flag on last bit");
        w = wm_writes;
        exec(TMI_OP_BIT_SET, 16'h0020);
        check1(range_error_flag, 1'b1, "flag past table");
        check16(16'(last_lat), 16'h0002, "bad bit latency");
        check16(16'(wm_writes - w), 16'h0000, "no write past table");
        @(posedge clock);
        scan_end <= 1'b1;
        @(posedge clock);
        scan_end <= 1'b0;
        @(negedge clock);
        check1(range_error_flag, 1'b0, "flag after scan end");
        exec(TMI_OP_BIT_CLEAR, 16'h0020);
        check1(range_error_flag, 1'b1, "flag again");
        exec(TMI_OP_BIT_CLEAR, 16'h001f);
        check1(range_error_flag, 1'b0, "flag after reuse");
        check16(wmem[16'h0061], 16'h1000, "bit clear word 1");
        check16(acc_value, 16'h0060, "start kept in acc");
    endtask : t_bits

    task automatic t_fill;
        int w;
        wmem[16'h0080] = 16'habcd;
        exec(TMI_OP_LOAD, 16'h0004);
        exec(TMI_OP_LOAD_ADDR, 16'h0070);
        exec(TMI_OP_FILL_CONST, 16'h1234);
        check16(16'(last_lat), 16'h0006, "fill latency");
        for (int i = 0; i < 4; i++) begin
            check16(wmem[16'h0070 + 16'(i)], 16'h1234, "fill word");
        end
        check16(wmem[16'h0074], 16'h0000, "past fill");
        exec(TMI_OP_LOAD, 16'h0002);
        exec(TMI_OP_LOAD_ADDR, 16'h0090);
        exec(TMI_OP_FILL_WORD, 16'h0080);
        check16(16'(last_lat), 16'h0006, "fill word latency");
        check16(wmem[16'h0091], 16'habcd, "fill from word");
        check16(wmem[16'h0090], 16'habcd, "fill from word first");
        exec(TMI_OP_LOAD, 16'h0010);
        exec(TMI_OP_LOAD_ADDR, 16'hfff0);
        exec(TMI_OP_FILL_CONST, 16'h0007);
        check1(range_error_flag, 1'b0, "fill to memory end");
        check16(wmem[16'hffff], 16'h0007, "last memory word");
        w = wm_writes;
        exec(TMI_OP_LOAD, 16'h0011);
        exec(TMI_OP_LOAD_ADDR, 16'hfff0);
        exec(TMI_OP_FILL_CONST, 16'h0009);
        check1(range_error_flag, 1'b1, "fill past memory");
        check16(16'(last_lat), 16'h0002, "bad fill latency");
        check16(16'(wm_writes - w), 16'h0000, "bad fill writes");
        exec(TMI_OP_NOP, 16'h5555);
        check16(16'(last_lat), 16'h0001, "nop latency");
        check16(acc_value, 16'hfff0, "nop leaves acc");
    endtask : t_fill

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        for (int i = 0; i < 65536; i++) begin
            wmem[i] = 16'h0000;
            pmem[i] = 16'h0000;
        end
        t_reset;
        t_copy_in;
        t_copy_out;
        t_bits;
        t_fill;
        final_report;
    end

    initial begin
        #(50 * 4000);
        n_mismatch++;
        final_report;
    end

endmodule : tmi_table_unit_test
